// >>> rtb_far.sv
`timescale 1ns/1ns

// AHB-Lite slave: answers the inverted word address, optional wait
module rtb_far #(
  parameter int WAIT = 0
) (
  input  wire logic           clk_sys,
  input  wire logic           nrst,
  input  rtb_pkg::rtb_ahb_m_s m,
  output rtb_pkg::rtb_ahb_s_s s
);
  logic        dph_r;  // Data phase open
  logic        w_r;    // One wait still owed
  logic [31:0] a_r;    // Address held for data phase
  logic [31:0] pat_r;  // Noise outside data phase, never a stale word
  wire         rdy = !dph_r || !w_r;
  assign s = '{hready: rdy, hresp: 1'h0, hexokay: dph_r,
               hrdata: (dph_r && rdy) ? ~{a_r[31:2], 2'h0} : pat_r};

  // Address phase is taken only while ready
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      dph_r <= 1'h0;
      w_r   <= 1'h0;
      a_r   <= 32'h0;
      pat_r <= 32'h0;
    end else begin
      pat_r <= pat_r + 32'h1357_9BDF;
      w_r   <= rdy ? (WAIT != 0) : 1'h0;
      if (rdy) begin
        dph_r <= (m.htrans == rtb_pkg::HT_NSEQ);
        a_r   <= m.haddr;
      end
    end
  end
endmodule

// APB slave: always one wait state, data tagged with the address
module rtb_apb_far (
  input  wire logic           clk_sys,
  input  wire logic           nrst,
  input  rtb_pkg::rtb_apb_m_s m,
  output rtb_pkg::rtb_apb_s_s s
);
  logic        ph_r;   // Wait already spent
  logic [31:0] pat_r;  // Toggles so idle data is never trusted
  wire         rdy = m.penable && ph_r;
  assign s = '{pready: rdy, pslverr: 1'h0,
               prdata: rdy ? {12'hC00, m.paddr} : pat_r};

  // Access phase pacing
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ph_r  <= 1'h0;
      pat_r <= 32'h0;
    end else begin
      ph_r  <= m.penable && !ph_r;
      pat_r <= ~pat_r;
    end
  end
endmodule

// >>> rtb_pkg.sv
package rtb_pkg;
  // Address map limits
  localparam logic [31:0] CODE_HI = 32'h1FFF_FFFF;
  localparam logic [31:0] SYS_LO  = 32'h2000_0000;
  localparam logic [31:0] SYS_HI  = 32'hDFFF_FFFF;
  localparam logic [31:0] SYS2_LO = 32'hE010_0000;
  localparam logic [31:0] PP_LO   = 32'hE004_0000;
  localparam logic [31:0] PP_HI   = 32'hE00F_FFFF;
  // Peripheral address bits driven out
  localparam int PP_AW = 20;
  // Transfer type and size codes
  localparam logic [1:0] HT_IDLE = 2'h0;
  localparam logic [1:0] HT_NSEQ = 2'h2;
  localparam logic [1:0] SZ_B    = 2'h0;
  localparam logic [1:0] SZ_H    = 2'h1;
  localparam logic [1:0] SZ_W    = 2'h2;
  // Requesters, lowest index wins
  localparam int SRC_D = 0;
  localparam int SRC_I = 1;
  localparam int SRC_G = 2;
  // Ports
  localparam int P_IC = 0;
  localparam int P_DC = 1;
  localparam int P_SY = 2;
  localparam int P_PP = 3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_ADDR = 3'h2,
    ST_DATA = 3'h4
  } rtb_st_e;

  // Request from a requester, held until done
  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic        write;
    logic [1:0]  size;
    logic [31:0] wdata;
    logic        excl;
    logic        remap;
  } rtb_req_s;

  // Answer to a requester, done is a pulse
  typedef struct packed {
    logic        done;
    logic [31:0] rdata;
    logic        err;
    logic        exfail;
  } rtb_rsp_s;

  // Completion of one access on one port
  typedef struct packed {
    logic        done;
    logic [1:0]  src;
    logic        posted;
    logic        write;
    logic [31:0] addr;
    logic [31:0] data;
    logic        err;
    logic        exf;
  } rtb_ev_s;

  typedef struct packed {
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hmastlock;
    logic        hexcl;
  } rtb_ahb_m_s;

  typedef struct packed {
    logic        hready;
    logic        hresp;
    logic [31:0] hrdata;
    logic        hexokay;
  } rtb_ahb_s_s;

  typedef struct packed {
    logic [PP_AW-1:0]  paddr;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [31:0]       pwdata;
  } rtb_apb_m_s;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } rtb_apb_s_s;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [31:0] addr;
    logic [31:0] data;
  } rtb_trc_s;
endpackage

// >>> rtb_router.sv
// Overview of operation
// (R1) Code-region fetches go out the instruction port unless remapped
// (R2) Debugger never reaches the instruction port
// (R3) Instruction port fetches are always full words
// (R4) Code-region data and debug use data port
// (R5) Data port: core data before debug
// (R6) Unaligned accesses split into aligned pieces
// (R7) Split access stalls later data and debug
// (R8) Outside arbiter should favour data over fetch
// (R9) System ranges go out the system port
// (R10) System port: data, then fetch, then debug
// (R11) System port handles unaligned, remap, bit-band
// (R12) External peripheral range uses the APB port for data and debug; fetches there are answered inside
// (R13) APB port: core data before debug
// (R14) APB port drives only needed address bits
// (R15) Data trace only while global enable set
// (R16) Bit-band read-modify-write is locked, atomic
// (R17) Core data writes, except to the APB port, are posted, core continues
// (R18) Debug keeps working while system reset held
// (R19) Exclusive AHB transfers flagged, monitor answer returned except on posted writes; APB exclusives always fail
// (R20) Unmapped addresses answered inside, never driven
`timescale 1ns/1ns

// One AHB-Lite master: splits, bit-band and exclusive
module rtb_ahb_eng #(
  parameter bit          BB_EN = 1'b0,
  parameter logic [31:0] BBA0  = 32'h2200_0000,
  parameter logic [31:0] BBT0  = 32'h2000_0000,
  parameter logic [31:0] BBA1  = 32'h4200_0000,
  parameter logic [31:0] BBT1  = 32'h4000_0000
) (
  input  wire logic               clk_sys,
  input  wire logic               nrst,
  input  wire logic               start,
  input  rtb_pkg::rtb_req_s       sreq,
  input  wire logic [1:0]         ssrc,
  output logic                    idle,
  output rtb_pkg::rtb_ev_s        ev,
  output rtb_pkg::rtb_ahb_m_s     m,
  input  rtb_pkg::rtb_ahb_s_s     s
);
  rtb_pkg::rtb_st_e  st_r, st_nxt;  // Transfer phase
  rtb_pkg::rtb_req_s rq_r;          // Captured access
  rtb_pkg::rtb_ev_s  ev_r;          // Completion report
  logic [1:0]  src_r;               // Owner of the access
  logic [31:0] cur_r;               // Address of current piece
  logic [2:0]  left_r;              // Bytes still to move
  logic [31:0] res_r;               // Read bytes gathered so far
  logic [31:0] wd_r;                // Write data of this piece
  logic [31:0] res_nxt;
  logic        err_r, exf_r;        // Sticky per access
  logic        bb_r, bbw_r;         // Bit-band, and its write leg
  logic [2:0]  bit_r;               // Bit-band bit number

  // Bit-band alias decode; alias word maps to one target bit
  wire hit0 = BB_EN && sreq.addr[31:25] == BBA0[31:25];
  wire hit1 = BB_EN && sreq.addr[31:25] == BBA1[31:25];
  wire bb_hit = hit0 || hit1;
  wire [31:0] bb_tgt = {hit0 ? BBT0[31:20] : BBT1[31:20],
                        sreq.addr[24:5]};

  // Largest aligned piece that fits the remaining bytes
  wire p_b = cur_r[0] || left_r == 3'h1;
  wire p_h = !p_b && (cur_r[1] || left_r < 3'h4);
  wire [2:0] p_n = p_b ? 3'h1 : (p_h ? 3'h2 : 3'h4);
  wire [1:0] p_sz = p_b ? rtb_pkg::SZ_B
                        : (p_h ? rtb_pkg::SZ_H : rtb_pkg::SZ_W);
  wire [2:0] p_idx = cur_r[2:0] - rq_r.addr[2:0];
  wire last = left_r == p_n;
  wire more_bbw = bb_r && rq_r.write && !bbw_r;
  wire hw = bb_r ? bbw_r : rq_r.write;
  wire cap = st_r == rtb_pkg::ST_DATA && s.hready;
  wire fin = cap && last && !more_bbw;

  // Write lanes: rotate by start offset; bit-band merges one bit
  wire [63:0] dbl = {rq_r.wdata, rq_r.wdata} << {rq_r.addr[1:0], 3'h0};
  wire [7:0] mb = (res_r[7:0] & ~(8'h01 << bit_r))
                | (8'(rq_r.wdata[0]) << bit_r);
  wire [31:0] wd_nxt = bbw_r ? {4{mb}} : dbl[63:32];

  // Gather read lanes into access byte order
  for (genvar k = 0; k < 4; k++) begin : g_lane
    wire [2:0] rel = 3'(k) - p_idx;
    wire [1:0] lane = rq_r.addr[1:0] + 2'(k);
    assign res_nxt[8*k +: 8] = (cap && !hw && rel < p_n)
                             ? s.hrdata[{lane, 3'h0} +: 8]
                             : res_r[8*k +: 8];
  end

  // Phase sequencing; idle only after the last piece
  always_comb begin
    unique case (st_r)
      rtb_pkg::ST_IDLE: st_nxt = start ? rtb_pkg::ST_ADDR : rtb_pkg::ST_IDLE;
      rtb_pkg::ST_ADDR: st_nxt = s.hready ? rtb_pkg::ST_DATA : rtb_pkg::ST_ADDR;
      rtb_pkg::ST_DATA: begin
        if (!s.hready) st_nxt = rtb_pkg::ST_DATA;
        else if (fin) st_nxt = rtb_pkg::ST_IDLE;
        else st_nxt = rtb_pkg::ST_ADDR;
      end
      default: st_nxt = rtb_pkg::ST_IDLE;
    endcase
  end

  // Capture, piece stepping and completion report
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_r <= rtb_pkg::ST_IDLE;
      rq_r <= '0;
      src_r <= 2'h0;
      cur_r <= 32'h0;
      left_r <= 3'h0;
      res_r <= 32'h0;
      wd_r <= 32'h0;
      err_r <= 1'b0;
      exf_r <= 1'b0;
      bb_r <= 1'b0;
      bbw_r <= 1'b0;
      bit_r <= 3'h0;
      ev_r <= '0;
    end else begin
      st_r <= st_nxt;
      res_r <= res_nxt;
      ev_r.done <= fin;
      if (st_r == rtb_pkg::ST_IDLE && start) begin
        rq_r <= sreq;
        src_r <= ssrc;
        err_r <= 1'b0;
        exf_r <= 1'b0;
        bbw_r <= 1'b0;
        bit_r <= sreq.addr[4:2];
        bb_r <= bb_hit; // R11
        if (bb_hit) begin
          rq_r.addr <= bb_tgt; // R11
          rq_r.size <= rtb_pkg::SZ_B;
          cur_r <= bb_tgt;
          left_r <= 3'h1;
        end else begin
          cur_r <= sreq.addr;
          left_r <= 3'h1 << sreq.size;
        end
      end
      if (st_r == rtb_pkg::ST_ADDR && s.hready) wd_r <= wd_nxt;
      if (cap) begin
        err_r <= err_r | s.hresp;
        exf_r <= exf_r | (rq_r.excl & !s.hexokay); // R19
        if (!last) begin
          cur_r <= cur_r + {29'h0, p_n}; // R6
          left_r <= left_r - p_n;
        end else if (more_bbw) begin
          bbw_r <= 1'b1; // R16
        end
      end
      if (fin) begin
        ev_r.src <= src_r;
        ev_r.posted <= rq_r.write && src_r == 2'(rtb_pkg::SRC_D);
        ev_r.write <= rq_r.write;
        ev_r.addr <= rq_r.addr;
        ev_r.err <= err_r | s.hresp;
        ev_r.exf <= exf_r | (rq_r.excl & !s.hexokay);
        if (rq_r.write) ev_r.data <= rq_r.wdata;
        else if (bb_r) ev_r.data <= {31'h0, res_nxt[bit_r]};
        else ev_r.data <= res_nxt;
      end
    end
  end

  // Bus drive from registered state; lock spans the whole RMW
  assign idle = st_r == rtb_pkg::ST_IDLE;
  assign ev = ev_r;
  assign m.haddr = cur_r;
  assign m.htrans = st_r == rtb_pkg::ST_ADDR ? rtb_pkg::HT_NSEQ
                                             : rtb_pkg::HT_IDLE;
  assign m.hwrite = hw;
  assign m.hsize = {1'b0, p_sz};
  assign m.hwdata = wd_r;
  assign m.hmastlock = bb_r && !idle; // R16
  assign m.hexcl = rq_r.excl; // R19

  a_piece_align: assert property (@(posedge clk_sys) disable iff (!nrst)
    st_r == rtb_pkg::ST_ADDR |-> !cur_r[0] || p_sz == rtb_pkg::SZ_B
      and (p_sz != rtb_pkg::SZ_W || cur_r[1:0] == 2'h0)) // R6
    else $error("piece not aligned");
  a_split_busy: assert property (@(posedge clk_sys) disable iff (!nrst)
    cap && !last |=> st_r == rtb_pkg::ST_ADDR && left_r != 3'h0) // R7
    else $error("split access ended early");
  a_bb_lock: assert property (@(posedge clk_sys) disable iff (!nrst)
    cap && more_bbw |=> m.hmastlock && m.hwrite
      && st_r == rtb_pkg::ST_ADDR) // R16
    else $error("bit-band write not locked");
endmodule

// Router: decodes, arbitrates and answers three requesters
module rtb_router (
  input  wire logic           clk_sys,
  input  wire logic           nrst,
  input  wire logic           system_reset_low,
  input  wire logic           trace_global_enable,
  input  rtb_pkg::rtb_req_s   req_data,
  input  rtb_pkg::rtb_req_s   req_fetch,
  input  rtb_pkg::rtb_req_s   req_debug,
  output rtb_pkg::rtb_rsp_s   rsp_data,
  output rtb_pkg::rtb_rsp_s   rsp_fetch,
  output rtb_pkg::rtb_rsp_s   rsp_debug,
  output rtb_pkg::rtb_ahb_m_s instruction_code_port_m,
  input  rtb_pkg::rtb_ahb_s_s instruction_code_port_s,
  output rtb_pkg::rtb_ahb_m_s data_code_port_m,
  input  rtb_pkg::rtb_ahb_s_s data_code_port_s,
  output rtb_pkg::rtb_ahb_m_s system_port_m,
  input  rtb_pkg::rtb_ahb_s_s system_port_s,
  output rtb_pkg::rtb_apb_m_s private_peripheral_port_m,
  input  rtb_pkg::rtb_apb_s_s private_peripheral_port_s,
  output rtb_pkg::rtb_trc_s   bus_trace_macrocell
);
  rtb_pkg::rtb_req_s   rq [3];      // Requests by index
  rtb_pkg::rtb_rsp_s   rsp_r [3];   // Answers by index
  rtb_pkg::rtb_req_s   ereq [3];    // Request fed to each AHB port
  rtb_pkg::rtb_ev_s    ev [4];      // Completions by port
  rtb_pkg::rtb_ahb_m_s am [3];
  rtb_pkg::rtb_ahb_s_s as [3];
  rtb_pkg::rtb_st_e    pst_r;       // Peripheral port phase
  rtb_pkg::rtb_req_s   prq_r;
  rtb_pkg::rtb_ev_s    pev_r;       // Peripheral port completion
  rtb_pkg::rtb_trc_s   trc_r;
  logic [1:0]  psrc_r;
  logic [1:0]  srst_r;              // System reset synchroniser
  logic        busy_r [3];          // Requester has one in flight
  logic [3:0]  tgt [3];             // One-hot port, zero is internal
  logic [2:0]  live, intl, start_s, post;
  logic [2:0]  gnt [4];             // Grant per port per requester
  logic [1:0]  gidx [4];
  logic [3:0]  idle;

  assign rq[rtb_pkg::SRC_D] = req_data;
  assign rq[rtb_pkg::SRC_I] = req_fetch;
  assign rq[rtb_pkg::SRC_G] = req_debug;

  // Pin synchroniser; only core requesters are held by it
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) srst_r <= 2'h0;
    else srst_r <= {srst_r[0], system_reset_low};
  end
  wire core_ok = srst_r[1];

  // Address decode per requester
  for (genvar i = 0; i < 3; i++) begin : g_dec
    wire [31:0] a = rq[i].addr;
    wire in_code = a <= rtb_pkg::CODE_HI;
    wire in_sys = (a >= rtb_pkg::SYS_LO && a <= rtb_pkg::SYS_HI)
               || a >= rtb_pkg::SYS2_LO;
    wire in_pp = a >= rtb_pkg::PP_LO && a <= rtb_pkg::PP_HI;
    wire fp = i == rtb_pkg::SRC_I;
    wire remap = fp && rq[i].remap;
    // Debug is served during system reset, core is not
    wire ok = i == rtb_pkg::SRC_G || core_ok; // R18
    assign live[i] = rq[i].valid && ok && !busy_r[i];
    assign tgt[i][rtb_pkg::P_IC] = fp && in_code && !remap; // R1 R2
    assign tgt[i][rtb_pkg::P_DC] = !fp && in_code; // R4
    assign tgt[i][rtb_pkg::P_SY] = in_sys || remap; // R9 R11
    assign tgt[i][rtb_pkg::P_PP] = !fp && in_pp; // R12
    assign intl[i] = live[i] && tgt[i] == 4'h0; // R20
    assign start_s[i] = gnt[0][i] | gnt[1][i] | gnt[2][i] | gnt[3][i];
    assign post[i] = start_s[i] && i == rtb_pkg::SRC_D
                  && rq[i].write && !tgt[i][rtb_pkg::P_PP]; // R17
  end

  // Fixed priority: data, then fetch, then debug; wait for idle
  for (genvar p = 0; p < 4; p++) begin : g_arb
    wire [2:0] col = {live[2] & tgt[2][p], live[1] & tgt[1][p],
                      live[0] & tgt[0][p]};
    assign gnt[p] = idle[p] ? (col & (~col + 3'h1)) : 3'h0; // R5 R7 R10 R13
    assign gidx[p] = {gnt[p][2], gnt[p][1]};
  end

  // Fetch port sees whole aligned words only
  always_comb begin
    ereq[rtb_pkg::P_IC] = rq[rtb_pkg::SRC_I];
    ereq[rtb_pkg::P_IC].addr[1:0] = 2'h0; // R3
    ereq[rtb_pkg::P_IC].size = rtb_pkg::SZ_W; // R3
    ereq[rtb_pkg::P_IC].write = 1'b0; // R3
    ereq[rtb_pkg::P_DC] = rq[gidx[rtb_pkg::P_DC]];
    ereq[rtb_pkg::P_SY] = rq[gidx[rtb_pkg::P_SY]];
  end

  // Three AHB-Lite masters; only the system port decodes bit-band
  for (genvar p = 0; p < 3; p++) begin : g_eng
    rtb_ahb_eng #(.BB_EN(p == rtb_pkg::P_SY)) u_eng (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .start   (|gnt[p]),
      .sreq    (ereq[p]),
      .ssrc    (gidx[p]),
      .idle    (idle[p]),
      .ev      (ev[p]),
      .m       (am[p]),
      .s       (as[p])
    );
  end
  assign instruction_code_port_m = am[rtb_pkg::P_IC];
  assign data_code_port_m = am[rtb_pkg::P_DC];
  assign system_port_m = am[rtb_pkg::P_SY];
  assign as[rtb_pkg::P_IC] = instruction_code_port_s;
  assign as[rtb_pkg::P_DC] = data_code_port_s;
  assign as[rtb_pkg::P_SY] = system_port_s;

  // APB master: setup then access until ready
  wire p_go = |gnt[rtb_pkg::P_PP];
  wire p_end = pst_r == rtb_pkg::ST_DATA && private_peripheral_port_s.pready;
  assign idle[rtb_pkg::P_PP] = pst_r == rtb_pkg::ST_IDLE;
  // One driver per completion slot keeps the array purely continuous
  assign ev[rtb_pkg::P_PP] = pev_r;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pst_r <= rtb_pkg::ST_IDLE;
      prq_r <= '0;
      psrc_r <= 2'h0;
      pev_r <= '0;
    end else begin
      pev_r.done <= p_end;
      unique case (pst_r)
        rtb_pkg::ST_IDLE: if (p_go) begin
          pst_r <= rtb_pkg::ST_ADDR;
          prq_r <= rq[gidx[rtb_pkg::P_PP]];
          psrc_r <= gidx[rtb_pkg::P_PP];
        end
        rtb_pkg::ST_ADDR: pst_r <= rtb_pkg::ST_DATA;
        rtb_pkg::ST_DATA: if (p_end) begin
          pst_r <= rtb_pkg::ST_IDLE;
          pev_r.src <= psrc_r;
          pev_r.posted <= 1'b0;
          pev_r.write <= prq_r.write;
          pev_r.addr <= prq_r.addr;
          pev_r.data <= prq_r.write ? prq_r.wdata
            : private_peripheral_port_s.prdata;
          pev_r.err <= private_peripheral_port_s.pslverr;
          pev_r.exf <= prq_r.excl; // R19
        end
        default: pst_r <= rtb_pkg::ST_IDLE;
      endcase
    end
  end
  // Only the low address bits leave the block
  assign private_peripheral_port_m.paddr =
    prq_r.addr[rtb_pkg::PP_AW-1:0]; // R14
  assign private_peripheral_port_m.psel = !idle[rtb_pkg::P_PP];
  assign private_peripheral_port_m.penable = pst_r == rtb_pkg::ST_DATA;
  assign private_peripheral_port_m.pwrite = prq_r.write;
  assign private_peripheral_port_m.pwdata = prq_r.wdata;

  // Answers: internal, posted write, or a port completion
  for (genvar i = 0; i < 3; i++) begin : g_rsp
    logic [3:0] hit;
    for (genvar p = 0; p < 4; p++) begin : g_hit
      assign hit[p] = ev[p].done && ev[p].src == 2'(i) && !ev[p].posted;
    end
    wire [31:0] rd = ({32{hit[0]}} & ev[0].data) | ({32{hit[1]}} & ev[1].data)
                   | ({32{hit[2]}} & ev[2].data) | ({32{hit[3]}} & ev[3].data);
    always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
        rsp_r[i] <= '0;
        busy_r[i] <= 1'b0;
      end else begin
        busy_r[i] <= start_s[i] | intl[i] | (busy_r[i] & !rsp_r[i].done);
        rsp_r[i].done <= intl[i] | post[i] | (|hit); // R17 R20
        rsp_r[i].rdata <= rd;
        // Unmapped fetches fault; other unmapped space reads zero
        rsp_r[i].err <= (intl[i] && i == rtb_pkg::SRC_I)
          | |(hit & {ev[3].err, ev[2].err, ev[1].err, ev[0].err});
        rsp_r[i].exfail <= |(hit & {ev[3].exf, ev[2].exf,
                                    ev[1].exf, ev[0].exf}); // R19
      end
    end
  end
  assign rsp_data = rsp_r[rtb_pkg::SRC_D];
  assign rsp_fetch = rsp_r[rtb_pkg::SRC_I];
  assign rsp_debug = rsp_r[rtb_pkg::SRC_G];

  // Data trace of core data completions; first port wins a clash
  wire [2:0] td;
  for (genvar p = 1; p < 4; p++) begin : g_td
    assign td[p-1] = ev[p].done && ev[p].src == 2'(rtb_pkg::SRC_D);
  end
  wire [1:0] tp = td[0] ? 2'h1 : (td[1] ? 2'h2 : 2'h3);
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) trc_r <= '0;
    else begin
      trc_r.valid <= trace_global_enable && |td; // R15
      trc_r.write <= ev[tp].write;
      trc_r.addr <= ev[tp].addr;
      trc_r.data <= ev[tp].data;
    end
  end
  assign bus_trace_macrocell = trc_r;

  a_fetch_word: assert property (@(posedge clk_sys) disable iff (!nrst)
    am[0].htrans == rtb_pkg::HT_NSEQ |-> am[0].hsize == 3'h2
      && am[0].haddr[1:0] == 2'h0 && !am[0].hwrite) // R3
    else $error("fetch not a word read");
  a_fetch_owner: assert property (@(posedge clk_sys) disable iff (!nrst)
    gnt[0][rtb_pkg::SRC_G] == 1'b0 && gnt[0][rtb_pkg::SRC_D] == 1'b0) // R2
    else $error("non-fetch on fetch port");
  a_fetch_range: assert property (@(posedge clk_sys) disable iff (!nrst)
    |gnt[0] |=> am[0].haddr <= rtb_pkg::CODE_HI) // R1
    else $error("fetch port outside code");
  a_data_code_port_prio: assert property (@(posedge clk_sys) disable iff (!nrst)
    idle[1] && live[0] && tgt[0][1] |-> gnt[1] == 3'h1) // R5
    else $error("data lost data port");
  a_sys_prio: assert property (@(posedge clk_sys) disable iff (!nrst)
    idle[2] && !live[0] && live[1] && tgt[1][2] |-> gnt[2] == 3'h2) // R10
    else $error("fetch lost system port");
  a_sys_range: assert property (@(posedge clk_sys) disable iff (!nrst)
    gnt[2][2] |-> rq[2].addr >= rtb_pkg::SYS_LO
      && !(rq[2].addr > rtb_pkg::SYS_HI && rq[2].addr < rtb_pkg::SYS2_LO)) // R9
    else $error("debug on system port off range");
  a_pp_order: assert property (@(posedge clk_sys) disable iff (!nrst)
    p_go |=> private_peripheral_port_m.psel
      && !private_peripheral_port_m.penable
      ##1 private_peripheral_port_m.penable) // R12 R13
    else $error("peripheral access sequence");
  a_core_held: assert property (@(posedge clk_sys) disable iff (!nrst)
    !core_ok |-> start_s[1:0] == 2'h0 && intl[1:0] == 2'h0) // R18
    else $error("core access during system reset");
  a_trace_gate: assert property (@(posedge clk_sys) disable iff (!nrst)
    trc_r.valid |-> $past(trace_global_enable)) // R15
    else $error("trace without enable");
  a_intl_quiet: assert property (@(posedge clk_sys) disable iff (!nrst)
    intl[0] |-> start_s[0] == 1'b0 ##1 rsp_r[0].done) // R20
    else $error("internal access not answered");
endmodule

// >>> tb.sv
`timescale 1ns/1ns

module tb;
  logic                clk_sys;
  logic                nrst;
  logic                srl;      // System reset pin, low active
  logic                tge;      // Global trace enable
  rtb_pkg::rtb_req_s   rq [3];   // Data, fetch, debug
  rtb_pkg::rtb_rsp_s   rs [3];
  rtb_pkg::rtb_ahb_m_s am [3];   // Instruction, data code, system
  rtb_pkg::rtb_ahb_s_s as [3];
  rtb_pkg::rtb_apb_m_s pm;
  rtb_pkg::rtb_apb_s_s ps;
  rtb_pkg::rtb_trc_s   trc;
  int                  fails;
  int                  compares;
  int                  cnt [5];  // Transfers per port, then trace pulses
  int                  c0 [5];   // Snapshot of cnt
  logic [2:0]          ic_sz;    // Last instruction port size
  logic [19:0]         pa;       // Last peripheral address
  logic [31:0]         rdv [3];  // Last answer per requester
  time                 t [3];    // Time of last done

  rtb_router rtb_router_i (
    .clk_sys, .nrst, .system_reset_low(srl), .trace_global_enable(tge),
    .req_data(rq[0]), .req_fetch(rq[1]), .req_debug(rq[2]),
    .rsp_data(rs[0]), .rsp_fetch(rs[1]), .rsp_debug(rs[2]),
    .instruction_code_port_m(am[0]), .instruction_code_port_s(as[0]),
    .data_code_port_m(am[1]), .data_code_port_s(as[1]),
    .system_port_m(am[2]), .system_port_s(as[2]),
    .private_peripheral_port_m(pm), .private_peripheral_port_s(ps),
    .bus_trace_macrocell(trc));

  // System port answers slowly, the code ports at once; separate code
  // slaves never make data code wait on fetch
  for (genvar g = 0; g < 3; g++) begin : g_far
    rtb_far #(.WAIT(g == 2)) rtb_far_i (.clk_sys, .nrst, .m(am[g]),
                                        .s(as[g]));
  end
  rtb_apb_far rtb_apb_far_i (.clk_sys, .nrst, .m(pm), .s(ps));

  initial begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Port monitor, at the falling edge where outputs are settled
  always @(negedge clk_sys) begin
    for (int p = 0; p < 3; p++)
      if (am[p].htrans == rtb_pkg::HT_NSEQ && as[p].hready) cnt[p]++;
    if (am[0].htrans == rtb_pkg::HT_NSEQ) ic_sz <= am[0].hsize;
    if (pm.psel && !pm.penable) begin
      cnt[3]++;
      pa <= pm.paddr;
    end
    if (trc.valid) cnt[4]++;
  end

  task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask

  // Word the AHB slaves return for an address
  function logic [31:0] wd(logic [31:0] a);
    return ~{a[31:2], 2'h0};
  endfunction

  function logic [7:0] bt(logic [31:0] a);
    return 8'(wd(a) >> {a[1:0], 3'h0});
  endfunction

  // One access: raise at negedge, hold until done, drop next negedge
  task automatic acc(int w, logic [31:0] a, logic [1:0] sz,
                     logic wr = 1'h0, logic [31:0] wv = 32'h0);
    @(negedge clk_sys);
    rq[w] = '{valid: 1'h1, addr: a, size: sz, write: wr, wdata: wv,
              default: '0};
    for (int i = 0; i < 300; i++) begin
      @(posedge clk_sys);
      #1;
      if (rs[w].done === 1'h1) break;
    end
    chk("done", rs[w].done, 32'h1);
    rdv[w] = rs[w].rdata;
    t[w] = $time;
    @(negedge clk_sys);
    rq[w].valid = 1'h0;
  endtask

  task t_code();
    c0 = cnt;
    acc(0, 32'h0000_0100, rtb_pkg::SZ_W);
    chk("dc rd", rdv[0], wd(32'h100));
    acc(1, 32'h0000_0202, rtb_pkg::SZ_H);
    chk("ic size", ic_sz, 32'h2);
    acc(2, 32'h1FFF_FFFC, rtb_pkg::SZ_W);
    chk("dbg rd", rdv[2], wd(32'h1FFF_FFFC));
    chk("ic cnt", cnt[0] - c0[0], 1);
    chk("dc cnt", cnt[1] - c0[1], 2);
  endtask

  task t_map();
    c0 = cnt;
    acc(0, 32'h2000_0010, rtb_pkg::SZ_W);
    chk("sy rd", rdv[0], wd(32'h2000_0010));
    acc(2, 32'hF000_0000, rtb_pkg::SZ_W);
    chk("sy hi", rdv[2], wd(32'hF000_0000));
    acc(1, 32'hDFFF_FFF0, rtb_pkg::SZ_W);
    chk("sy fetch", rdv[1], wd(32'hDFFF_FFF0));
    chk("sy cnt", cnt[2] - c0[2], 3);
    acc(0, 32'hE004_0010, rtb_pkg::SZ_W);
    chk("pp rd", rdv[0], 32'hC004_0010);
    chk("pp addr", pa, 32'h4_0010);
    acc(2, 32'hE00F_FFFC, rtb_pkg::SZ_W);
    chk("pp dbg", rdv[2], 32'hC00F_FFFC);
    acc(0, 32'hE000_0000, rtb_pkg::SZ_W);
    chk("int rd", rdv[0], 32'h0);
    chk("pp cnt", cnt[3] - c0[3], 2);
  endtask

  // Unaligned word at +1 races a debug read on the data code port
  task t_split();
    c0 = cnt;
    fork
      acc(0, 32'h0000_0101, rtb_pkg::SZ_W);
      acc(2, 32'h0000_0108, rtb_pkg::SZ_W);
    join
    chk("split cnt", cnt[1] - c0[1], 4);
    chk("split rd", rdv[0], {bt(32'h104), bt(32'h103), bt(32'h102),
                             bt(32'h101)});
    chk("dbg late", t[2] > t[0], 1);
    chk("dbg rd", rdv[2], wd(32'h108));
  endtask

  task t_prio();
    fork
      acc(2, 32'h2000_0100, rtb_pkg::SZ_W);
      acc(1, 32'h2000_0200, rtb_pkg::SZ_W);
      acc(0, 32'h2000_0300, rtb_pkg::SZ_W);
    join
    chk("sy order", (t[0] < t[1]) && (t[1] < t[2]), 1);
    fork
      acc(2, 32'hE004_0020, rtb_pkg::SZ_W);
      acc(0, 32'hE004_0030, rtb_pkg::SZ_W);
    join
    chk("pp order", t[0] < t[2], 1);
  endtask

  task t_trace();
    c0 = cnt;
    tge = 1'h1;
    acc(0, 32'h2000_0040, rtb_pkg::SZ_W);
    tge = 1'h0;
    acc(0, 32'h2000_0044, rtb_pkg::SZ_W);
    repeat (3) @(posedge clk_sys);
    #1;
    chk("trc", cnt[4] - c0[4], 1);
  endtask

  // Bit-band read, then a posted bit-band write: read leg, write leg
  task t_bb();
    c0 = cnt;
    acc(0, 32'h2200_0104, rtb_pkg::SZ_W);
    chk("bb rd", rdv[0], (bt(32'h2000_0008) >> 1) & 8'h1);
    t[1] = $time;
    acc(0, 32'h2200_0104, rtb_pkg::SZ_W, 1'h1, 32'h1);
    chk("posted", t[0] - t[1] < 40, 1);
    repeat (8) @(negedge clk_sys);
    chk("bb legs", cnt[2] - c0[2], 3);
  endtask

  // Debug must finish while core data waits on the system reset
  task t_rst();
    @(negedge clk_sys);
    srl = 1'h0;
    // Let the two-stage pin synchroniser see the low level first
    repeat (2) @(negedge clk_sys);
    fork
      acc(0, 32'h2000_0050, rtb_pkg::SZ_W);
      begin
        acc(2, 32'h2000_0060, rtb_pkg::SZ_W);
        chk("dbg in rst", rdv[2], wd(32'h2000_0060));
        srl = 1'h1;
      end
    join
    chk("core held", t[0] > t[2], 1);
  endtask

  task results();
    if (fails == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    nrst = 1'h0;
    srl = 1'h1;
    tge = 1'h0;
    foreach (rq[i]) rq[i] = '0;
    repeat (20) @(posedge clk_sys);
    @(negedge clk_sys);
    nrst = 1'h1;
    repeat (3) @(negedge clk_sys);
    t_code();
    t_map();
    t_split();
    t_prio();
    t_trace();
    t_bb();
    t_rst();
    results();
  end

  // Hang guard, far beyond the few hundred cycles needed
  initial begin
    #200000;
    fails++;
    results();
  end
endmodule
